// file: hdl/aer_recorder.sv
`timescale 1ns/1ps
// Functional notes
// - main alarm counter counts zero to 999
// - four per-input alarm sub-counters, 0 to 255
// - sequence end stores shot count 0-5
// - final trip adds ten to stored count
// - new entry pushes history down, drops oldest
// - middle digit 0 when breaker input energized
// - routed reset control clears registers and indicators
module aer_recorder
   import aer_pkg::*;
(
   input  wire logic               ref_clk_in,
   input  wire logic               rst_in,
   input  wire logic               reclose_initiation_one_in,
   input  wire logic               reclose_initiation_two_in,
   input  wire logic               reclose_initiation_three_in,
   input  wire logic               reclose_initiation_four_in,
   input  wire logic               reclose_inhibit_in,
   input  wire logic               reclose_control_input_in,
   input  wire logic               second_blocking_signal_in,
   input  wire logic               breaker_position_in,
   input  wire logic               register_reset_control_in,
   input  wire logic [SUB_COUNT-1:0] def_trip_alarm_in,
   input  wire logic               seq_end_in,
   input  wire logic [2:0]         seq_shots_in,
   input  wire logic               seq_final_trip_in,
   input  wire logic [ADDR_W-1:0]  reg_addr_in,
   input  wire logic [DATA_W-1:0]  reg_wdata_in,
   input  wire logic               reg_wr_in,
   input  wire logic               reg_rd_in,
   output logic [DATA_W-1:0]       reg_rdata_out,
   output logic                    irq_out,
   output logic                    indicator_clear_out
);
   logic [PIN_COUNT-1:0] pin_meta_q;
   logic [PIN_COUNT-1:0] pin_sync_q;
   logic [STAT_W-1:0]    ctrl_status_q;
   logic                 route_q;
   logic                 clear_regs;
   logic [MAIN_W-1:0]    main_count;
   logic                 main_at_max;
   logic [SUB_W-1:0]     sub_count [SUB_COUNT];
   logic [SUB_COUNT-1:0] sub_at_max;
   logic [HIST_W-1:0]    hist_q [HIST_DEPTH];
   logic [HIST_W-1:0]    hist_entry;
   logic [2:0]           shots_clamped;
   logic [IRQ_W-1:0]     irq_status_q;
   logic [IRQ_W-1:0]     irq_mask_q;
   logic [IRQ_W-1:0]     irq_events;
   logic [IRQ_W-1:0]     irq_w1c;
   logic                 alarm_any;
   logic                 sat_hit;
   logic [DATA_W-1:0]    read_mux;

   // packs three active signals into one weighted decimal digit (1, 2, 4)
   function automatic logic [2:0] weigh3(input logic w1, input logic w2, input logic w4);
      weigh3 = {w4, w2, w1};
   endfunction

   // every pin is foreign to this clock: two flops before anyone looks
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
      end else begin
         pin_meta_q <= {register_reset_control_in, breaker_position_in,
                        second_blocking_signal_in, reclose_control_input_in,
                        reclose_inhibit_in, reclose_initiation_four_in,
                        reclose_initiation_three_in, reclose_initiation_two_in,
                        reclose_initiation_one_in};
         pin_sync_q <= pin_meta_q;
      end
   end

   // live control-signal display, three digits packed as left|mid|right
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         ctrl_status_q <= '0;
      end else begin
         ctrl_status_q[ST_RIGHT_LSB +: 3] <= weigh3(pin_sync_q[PIN_INHIBIT],
                                                    pin_sync_q[PIN_CONTROL],
                                                    pin_sync_q[PIN_BLOCK2]);
         ctrl_status_q[ST_MID_BIT] <= ~pin_sync_q[PIN_BREAKER];
         ctrl_status_q[ST_LEFT_LSB +: 3] <= weigh3(pin_sync_q[PIN_INIT1],
                                                   pin_sync_q[PIN_INIT2],
                                                   pin_sync_q[PIN_INIT3]);
      end
   end

   // clearing only happens while the reset control is routed here; reset leaves it routed
   assign clear_regs = route_q & pin_sync_q[PIN_RRESET];

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         indicator_clear_out <= 1'b0;
      end else begin
         indicator_clear_out <= clear_regs;
      end
   end

   // simultaneous alarms from several inputs count once in the total
   assign alarm_any = |def_trip_alarm_in;

   aer_sat_counter #(
      .W   (MAIN_W),
      .MAX (MAIN_MAX)
   ) u_main_count (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .clear_in   (clear_regs),
      .inc_in     (alarm_any),
      .count_out  (main_count),
      .at_max_out (main_at_max)
   );

   genvar gi;
   generate
      for (gi = 0; gi < SUB_COUNT; gi++) begin : g_sub
         aer_sat_counter #(
            .W   (SUB_W),
            .MAX (SUB_MAX)
         ) u_sub_count (
            .ref_clk_in (ref_clk_in),
            .rst_in     (rst_in),
            .clear_in   (clear_regs),
            .inc_in     (def_trip_alarm_in[gi]),
            .count_out  (sub_count[gi]),
            .at_max_out (sub_at_max[gi])
         );
      end
   endgenerate

   // shot counts above five are impossible; clamp so the entry stays decodable
   assign shots_clamped = (seq_shots_in > MAX_SHOTS) ? MAX_SHOTS : seq_shots_in;
   assign hist_entry = {2'h0, shots_clamped}
                       + (seq_final_trip_in ? FINAL_TRIP_ADD : 5'h00);

   // history stack: head takes the new entry, each slot takes its neighbour
   generate
      for (gi = 0; gi < HIST_DEPTH; gi++) begin : g_hist
         always_ff @(posedge ref_clk_in) begin
            if (rst_in || clear_regs) begin
               hist_q[gi] <= '0;
            end else if (seq_end_in) begin
               if (gi == 0) begin
                  hist_q[gi] <= hist_entry;
               end else begin
                  // guarded index keeps the unused head branch inside the array
                  hist_q[gi] <= hist_q[(gi == 0) ? 0 : gi - 1];
               end
            end
         end
      end
   endgenerate

   // control register: routing switch for the reset control
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         route_q <= CTRL_ROUTE_RST;
      end else if (reg_wr_in && reg_addr_in == OFF_CONTROL) begin
         route_q <= reg_wdata_in[CTRL_ROUTE_BIT];
      end
   end

   // sticky events; a new event in the clearing cycle survives the clear
   assign sat_hit = (alarm_any && main_at_max) || |(def_trip_alarm_in & sub_at_max);
   assign irq_events = {sat_hit, seq_end_in & seq_final_trip_in, seq_end_in, alarm_any};
   assign irq_w1c = (reg_wr_in && reg_addr_in == OFF_IRQ_STATUS) ?
                    reg_wdata_in[IRQ_W-1:0] : '0;

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         irq_status_q <= '0;
      end else begin
         irq_status_q <= (irq_status_q & ~irq_w1c) | irq_events;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         irq_mask_q <= IRQ_MASK_RESET;
      end else if (reg_wr_in && reg_addr_in == OFF_IRQ_MASK) begin
         irq_mask_q <= reg_wdata_in[IRQ_W-1:0];
      end
   end

   // registered level, so it lags the status bit by one cycle
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(irq_status_q & irq_mask_q);
      end
   end

   // read decode; unmapped offsets answer zero
   always_comb begin
      read_mux = '0;
      if (reg_addr_in == OFF_CTRL_STATUS) begin
         read_mux = DATA_W'(ctrl_status_q);
      end else if (reg_addr_in == OFF_ALARM_MAIN) begin
         read_mux = DATA_W'(main_count);
      end else if (reg_addr_in == OFF_SHOT_HIST) begin
         read_mux = DATA_W'(hist_q[0]);
      end else if (reg_addr_in >= OFF_ALARM_SUB1 &&
                   reg_addr_in < OFF_ALARM_SUB1 + 5'(SUB_COUNT)) begin
         read_mux = DATA_W'(sub_count[2'(reg_addr_in - OFF_ALARM_SUB1)]);
      end else if (reg_addr_in >= OFF_HIST_SUB1 &&
                   reg_addr_in < OFF_HIST_SUB1 + 5'(HIST_DEPTH - 1)) begin
         read_mux = DATA_W'(hist_q[3'(reg_addr_in - OFF_HIST_SUB1) + 3'h1]);
      end else if (reg_addr_in == OFF_IRQ_STATUS) begin
         read_mux = DATA_W'(irq_status_q);
      end else if (reg_addr_in == OFF_IRQ_MASK) begin
         read_mux = DATA_W'(irq_mask_q);
      end else if (reg_addr_in == OFF_CONTROL) begin
         read_mux = DATA_W'(route_q);
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         reg_rdata_out <= '0;
      end else if (reg_rd_in) begin
         reg_rdata_out <= read_mux;
      end else begin
         reg_rdata_out <= '0;
      end
   end

   // checks
   main_cnt_inc_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      alarm_any && !clear_regs && main_count < MAIN_MAX |=> main_count == $past(main_count) + 10'h001)
      else $error("main alarm counter did not step");
   main_cnt_range_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      main_count <= MAIN_MAX)
      else $error("main alarm counter above its range");
   sub_cnt_inc_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      def_trip_alarm_in[1] && !clear_regs && sub_count[1] != SUB_MAX
      |=> sub_count[1] == $past(sub_count[1]) + 8'h01)
      else $error("sub-counter two did not step");
   sub_cnt_own_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !def_trip_alarm_in[0] && !clear_regs |=> $stable(sub_count[0]))
      else $error("sub-counter one moved without its own alarm");
   hist_store_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      seq_end_in && !seq_final_trip_in && !clear_regs && seq_shots_in <= MAX_SHOTS
      |=> hist_q[0] == {2'h0, $past(seq_shots_in)})
      else $error("shot count not stored in history head");
   hist_final_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      seq_end_in && seq_final_trip_in && !clear_regs && seq_shots_in <= MAX_SHOTS
      |=> hist_q[0] == {2'h0, $past(seq_shots_in)} + 5'h0a)
      else $error("final trip offset missing");
   hist_shift_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      seq_end_in && !clear_regs
      |=> hist_q[1] == $past(hist_q[0]) && hist_q[4] == $past(hist_q[3]))
      else $error("history stack did not push down");
   status_digits_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      ##1 ctrl_status_q[2:0] == $past({pin_sync_q[PIN_BLOCK2], pin_sync_q[PIN_CONTROL],
                                       pin_sync_q[PIN_INHIBIT]}))
      else $error("right digit weights wrong");
   breaker_digit_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      pin_sync_q[PIN_BREAKER] |=> !ctrl_status_q[ST_MID_BIT])
      else $error("breaker open not shown as zero");
   init_digit_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      ##1 ctrl_status_q[6:4] == $past({pin_sync_q[PIN_INIT3], pin_sync_q[PIN_INIT2],
                                      pin_sync_q[PIN_INIT1]}))
      else $error("left digit weights wrong");
   reg_clear_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      clear_regs |=> main_count == 10'h000 && hist_q[0] == 5'h00 && indicator_clear_out)
      else $error("routed reset did not clear registers");
   sat_hold_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      main_count == MAIN_MAX && !clear_regs |=> main_count == MAIN_MAX)
      else $error("main alarm counter wrapped");
   irq_level_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      irq_out == $past(|(irq_status_q & irq_mask_q)))
      else $error("interrupt output disagrees with status and mask");
endmodule

// file: hdl/aer_sat_counter.sv
`timescale 1ns/1ps
module aer_sat_counter #(
   parameter int         W   = 8,
   parameter logic [W-1:0] MAX = '1
) (
   input  wire logic         ref_clk_in,
   input  wire logic         rst_in,
   input  wire logic         clear_in,
   input  wire logic         inc_in,
   output logic [W-1:0]      count_out,
   output logic              at_max_out
);
   // counts events and holds at the limit; a wrap would fake a low total
   always_ff @(posedge ref_clk_in) begin
      if (rst_in || clear_in) begin
         count_out <= '0;
      end else if (inc_in && (count_out != MAX)) begin
         count_out <= count_out + W'(1);
      end
   end

   assign at_max_out = (count_out == MAX);
endmodule

// file: shared/aer_pkg.sv
package aer_pkg;
   // register bus geometry
   localparam int          ADDR_W          = 5;
   localparam int          DATA_W          = 16;
   // register offsets
   localparam logic [4:0]  OFF_CTRL_STATUS = 5'h00;
   localparam logic [4:0]  OFF_ALARM_MAIN  = 5'h08;
   localparam logic [4:0]  OFF_SHOT_HIST   = 5'h09;
   localparam logic [4:0]  OFF_ALARM_SUB1  = 5'h0a;
   localparam logic [4:0]  OFF_HIST_SUB1   = 5'h0e;
   localparam logic [4:0]  OFF_IRQ_STATUS  = 5'h12;
   localparam logic [4:0]  OFF_IRQ_MASK    = 5'h13;
   localparam logic [4:0]  OFF_CONTROL     = 5'h14;
   // counters
   localparam int          MAIN_W          = 10;
   localparam logic [9:0]  MAIN_MAX        = 10'h3e7;
   localparam int          SUB_W           = 8;
   localparam logic [7:0]  SUB_MAX         = 8'hff;
   localparam int          SUB_COUNT       = 4;
   // shot history stack
   localparam int          HIST_W          = 5;
   localparam int          HIST_DEPTH      = 5;
   localparam logic [2:0]  MAX_SHOTS       = 3'h5;
   localparam logic [4:0]  FINAL_TRIP_ADD  = 5'h0a;
   // control-signal status layout
   localparam int          STAT_W          = 7;
   localparam int          ST_RIGHT_LSB    = 0;
   localparam int          ST_MID_BIT      = 3;
   localparam int          ST_LEFT_LSB     = 4;
   // interrupt status / mask bits
   localparam int          IRQ_W           = 4;
   localparam int          IRQ_ALARM       = 0;
   localparam int          IRQ_SEQ_END     = 1;
   localparam int          IRQ_FINAL       = 2;
   localparam int          IRQ_SAT         = 3;
   localparam logic [3:0]  IRQ_MASK_RESET  = 4'h0;
   // control register: bit 0 routes the reset control to register clearing
   localparam int          CTRL_ROUTE_BIT  = 0;
   localparam logic        CTRL_ROUTE_RST  = 1'h1;
   // synchronised pin vector indices
   localparam int          PIN_COUNT       = 9;
   localparam int          PIN_INIT1       = 0;
   localparam int          PIN_INIT2       = 1;
   localparam int          PIN_INIT3       = 2;
   localparam int          PIN_INIT4       = 3;
   localparam int          PIN_INHIBIT     = 4;
   localparam int          PIN_CONTROL     = 5;
   localparam int          PIN_BLOCK2      = 6;
   localparam int          PIN_BREAKER     = 7;
   localparam int          PIN_RRESET      = 8;
endpackage

// file: testbench/aer_panel.sv
`timescale 1ns/1ps
// front-panel operator stepping through the register set over the plain bus
module aer_panel
   import aer_pkg::*;
(
   input  wire logic              ref_clk_in,
   input  wire logic [DATA_W-1:0] reg_rdata_in,
   output logic [ADDR_W-1:0]      reg_addr_out,
   output logic [DATA_W-1:0]      reg_wdata_out,
   output logic                   reg_wr_out,
   output logic                   reg_rd_out
);
   // bus idle from time zero so no strobe is seen before reset ends
   initial begin
      reg_addr_out  = '0;
      reg_wdata_out = '0;
      reg_wr_out    = 1'h0;
      reg_rd_out    = 1'h0;
   end
   // one-cycle write; slave never stalls
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge ref_clk_in);
      reg_addr_out  <= a;
      reg_wdata_out <= d;
      reg_wr_out    <= 1'h1;
      @(posedge ref_clk_in);
      reg_wr_out    <= 1'h0;
   endtask
   // read data stand only in the cycle after the strobe, so sample there
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge ref_clk_in);
      reg_addr_out <= a;
      reg_rd_out   <= 1'h1;
      @(posedge ref_clk_in);
      reg_rd_out   <= 1'h0;
      #1 d = reg_rdata_in;
   endtask
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb
   import aer_pkg::*;
;
   logic              ref_clk_in = 1'h0;
   logic              rst_in = 1'h1;
   logic [8:0]        pin = 9'h000;
   logic [3:0]        alarm = 4'h0;
   logic              seq_end = 1'h0;
   logic [2:0]        shots = 3'h0;
   logic              fin = 1'h0;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rdata;
   logic [DATA_W-1:0] rv;
   logic              wr;
   logic              rd;
   logic              irq;
   logic              clr;
   logic [31:0]       lf = 32'h0bbb;
   logic [4:0]        hist_e [5];
   int                main_e;
   int                sub_e [4];
   int                n_fail;
   int                tests_run;
   int                cyc;

   always #20 ref_clk_in = ~ref_clk_in;

   aer_recorder dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .reclose_initiation_one_in(pin[PIN_INIT1]), .reclose_initiation_two_in(pin[PIN_INIT2]),
      .reclose_initiation_three_in(pin[PIN_INIT3]),
      .reclose_initiation_four_in(pin[PIN_INIT4]), .reclose_inhibit_in(pin[PIN_INHIBIT]),
      .reclose_control_input_in(pin[PIN_CONTROL]),
      .second_blocking_signal_in(pin[PIN_BLOCK2]), .breaker_position_in(pin[PIN_BREAKER]),
      .register_reset_control_in(pin[PIN_RRESET]), .def_trip_alarm_in(alarm),
      .seq_end_in(seq_end), .seq_shots_in(shots), .seq_final_trip_in(fin),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .irq_out(irq), .indicator_clear_out(clr));

   aer_panel p (.ref_clk_in(ref_clk_in), .reg_rdata_in(rdata), .reg_addr_out(addr),
      .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // expected status word: left digit, breaker digit, right digit
   function automatic logic [15:0] stat_f(input logic [8:0] v);
      return {9'h000, v[PIN_INIT3], v[PIN_INIT2], v[PIN_INIT1], ~v[PIN_BREAKER],
              v[PIN_BLOCK2], v[PIN_CONTROL], v[PIN_INHIBIT]};
   endfunction
   task automatic chk_reg(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_bit(input string nm, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic rchk(input string nm, input logic [4:0] a, input logic [15:0] e);
      p.rd(a, rv);
      chk_reg(nm, e, rv);
   endtask
   // alarm pulses; the model saturates rather than wraps
   task automatic alarms(input int n, input logic one);
      logic [3:0] a;
      repeat (n) begin
         @(posedge ref_clk_in);
         lf = lfsr(lf);
         a = one ? 4'h1 : lf[3:0];
         alarm <= a;
         if (|a && main_e < 999) main_e++;
         for (int i = 0; i < 4; i++) if (a[i] && sub_e[i] < 255) sub_e[i]++;
      end
      @(posedge ref_clk_in);
      alarm <= 4'h0;
   endtask
   task automatic seq1(input logic [2:0] s, input logic f);
      @(posedge ref_clk_in);
      shots   <= s;
      fin     <= f;
      seq_end <= 1'h1;
      for (int i = 4; i > 0; i--) hist_e[i] = hist_e[i-1];
      hist_e[0] = 5'((s > 3'h5) ? 3'h5 : s) + (f ? 5'h0a : 5'h00);
      @(posedge ref_clk_in);
      seq_end <= 1'h0;
   endtask
   task automatic counts();
      rchk("main", OFF_ALARM_MAIN, 16'(main_e));
      for (int i = 0; i < 4; i++) rchk("sub", OFF_ALARM_SUB1 + 5'(i), 16'(sub_e[i]));
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // hang guard: whole run is about 1300 cycles
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         results();
      end
   end

   initial begin
      for (int i = 0; i < 5; i++) hist_e[i] = 5'h00;
      repeat (2) @(posedge ref_clk_in);
      rst_in <= 1'h0;
      repeat (4) @(posedge ref_clk_in);
      counts();
      rchk("mask", OFF_IRQ_MASK, 16'h0000);
      rchk("route", OFF_CONTROL, 16'h0001);
      rchk("unmapped", 5'h1f, 16'h0000);
      $display("test reset values done");
      // corners all-zero and all-one, then random pin patterns
      for (int i = 0; i < 10; i++) begin
         lf = lfsr(lf);
         @(posedge ref_clk_in);
         pin[7:0] <= (i == 0) ? 8'h00 : (i == 1) ? 8'hff : lf[7:0];
         repeat (4) @(posedge ref_clk_in);
         rchk("status", OFF_CTRL_STATUS, stat_f(pin));
      end
      $display("test status digits done");
      alarms(40, 1'h0);
      p.wr(OFF_ALARM_MAIN, 16'h0055);
      counts();
      $display("test alarm counts done");
      seq1(3'h7, 1'h1);
      repeat (6) begin
         lf = lfsr(lf);
         seq1(lf[2:0], lf[3]);
      end
      rchk("hist", OFF_SHOT_HIST, 16'(hist_e[0]));
      for (int i = 1; i < 5; i++) rchk("hsub", OFF_HIST_SUB1 + 5'(i - 1), 16'(hist_e[i]));
      $display("test history done");
      rchk("irqst", OFF_IRQ_STATUS, 16'h0007);
      p.wr(OFF_IRQ_MASK, 16'h0001);
      repeat (2) @(posedge ref_clk_in);
      #1 chk_bit("irq", 1'h1, irq);
      p.wr(OFF_IRQ_STATUS, 16'h000f);
      repeat (2) @(posedge ref_clk_in);
      #1 chk_bit("irq", 1'h0, irq);
      rchk("irqst", OFF_IRQ_STATUS, 16'h0000);
      alarms(1005, 1'h1);
      counts();
      rchk("irqst", OFF_IRQ_STATUS, 16'h0009);
      chk_bit("irq", 1'h1, irq);
      p.wr(OFF_IRQ_MASK, 16'h0000);
      repeat (2) @(posedge ref_clk_in);
      #1 chk_bit("irq", 1'h0, irq);
      $display("test saturation and interrupt done");
      @(posedge ref_clk_in);
      pin[PIN_RRESET] <= 1'h1;
      repeat (5) @(posedge ref_clk_in);
      #1 chk_bit("clear", 1'h1, clr);
      main_e = 0;
      sub_e = '{0, 0, 0, 0};
      for (int i = 0; i < 5; i++) hist_e[i] = 5'h00;
      counts();
      rchk("hist", OFF_SHOT_HIST, 16'h0000);
      @(posedge ref_clk_in);
      pin[PIN_RRESET] <= 1'h0;
      repeat (5) @(posedge ref_clk_in);
      #1 chk_bit("clear", 1'h0, clr);
      // unrouted reset control must leave the registers alone
      p.wr(OFF_CONTROL, 16'h0000);
      rchk("route", OFF_CONTROL, 16'h0000);
      @(posedge ref_clk_in);
      pin[PIN_RRESET] <= 1'h1;
      alarms(3, 1'h1);
      repeat (5) @(posedge ref_clk_in);
      #1 chk_bit("clear", 1'h0, clr);
      counts();
      $display("test reset control done");
      results();
   end
endmodule
